// ### design/spic_top.v
// Interrupt status, mask and write-only clear register of a serial port
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "spic_consts.vh"

module spic_top (
   // APB
   input  wire                      pclk,
   input  wire                      presetn,
   input  wire                      psel,
   input  wire                      penable,
   input  wire                      pwrite,
   input  wire [`SPIC_AW-1:0]       paddr,
   input  wire [`SPIC_DW-1:0]       pwdata,
   output wire                      pready,
   output wire                      pslverr,
   output wire [`SPIC_DW-1:0]       prdata,
   // Interrupt sources from the port, one-cycle pulses
   input  wire [`SPIC_NSRC-1:0]     src_event,
   // Clear strobes, masked status and combined interrupt
   output wire [`SPIC_NSRC-1:0]     clear_strobe,
   output wire [`SPIC_NSRC-1:0]     masked_status,
   output wire                      uart_irq
);

   // Registered state; rdata_d is the combinational read mux
   reg  [`SPIC_NSRC-1:0] raw_q;
   reg  [`SPIC_NSRC-1:0] mask_q;
   reg  [`SPIC_NSRC-1:0] clr_q;
   reg  [`SPIC_DW-1:0]   rdata_q;
   reg                   err_q;
   reg  [`SPIC_DW-1:0]   rdata_d;

   // Bus phase decode
   wire                  setup;
   wire                  access;
   wire                  wr_access;
   wire                  hit;

   // Register selects and write enables
   wire                  sel_raw;
   wire                  sel_mask;
   wire                  sel_mstat;
   wire                  sel_clear;
   wire                  mask_wr;
   wire                  clear_wr;

   // Per-field clear requests
   wire                  overrun_clear;
   wire                  break_clear;
   wire                  parity_error_clear;
   wire                  framing_error_clear;
   wire                  receive_timeout_clear;
   wire                  transmit_irq_clear;
   wire                  receive_irq_clear;
   wire                  data_set_ready_clear;
   wire                  carrier_detect_clear;
   wire                  clear_to_send_clear;
   wire                  ring_indicator_clear;
   wire [`SPIC_NSRC-1:0] clr_d;

   // Masked status and read words
   wire [`SPIC_NSRC-1:0] mstat;
   wire [`SPIC_DW-1:0]   rd_raw;
   wire [`SPIC_DW-1:0]   rd_mask;
   wire [`SPIC_DW-1:0]   rd_mstat;
   wire [`SPIC_DW-1:0]   rd_clear;

   // Zero wait states; address is judged in the setup cycle
   // Limitation: the port can never stall a transfer
   assign setup     = psel & ~penable;
   assign access    = psel & penable;
   assign wr_access = access & pwrite;
   assign pready    = 1'b1;
   assign pslverr   = access & err_q;
   assign prdata    = rdata_q;

   // Address decode
   assign sel_raw   = (paddr == `SPIC_ADDR_RAW_STATUS);
   assign sel_mask  = (paddr == `SPIC_ADDR_MASK);
   assign sel_mstat = (paddr == `SPIC_ADDR_MASKED_STATUS);
   assign sel_clear = (paddr == `SPIC_ADDR_INT_CLEAR);
   assign hit       = sel_raw |
                      sel_mask |
                      sel_mstat |
                      sel_clear;

   // Writes to the read-only status words are dropped quietly
   assign mask_wr   = wr_access & sel_mask;
   assign clear_wr  = wr_access & sel_clear;

   // Only bits 10..0 decode; whatever software puts in 31..11 is dropped
   assign overrun_clear         = clear_wr & pwdata[`SPIC_BIT_OVERRUN];
   assign break_clear           = clear_wr & pwdata[`SPIC_BIT_BREAK];
   assign parity_error_clear    = clear_wr & pwdata[`SPIC_BIT_PARITY];
   assign framing_error_clear   = clear_wr & pwdata[`SPIC_BIT_FRAMING];
   assign receive_timeout_clear = clear_wr & pwdata[`SPIC_BIT_RX_TIMEOUT];
   assign transmit_irq_clear    = clear_wr & pwdata[`SPIC_BIT_TRANSMIT];
   assign receive_irq_clear     = clear_wr & pwdata[`SPIC_BIT_RECEIVE];
   assign data_set_ready_clear  = clear_wr & pwdata[`SPIC_BIT_DSR];
   assign carrier_detect_clear  = clear_wr & pwdata[`SPIC_BIT_DCD];
   assign clear_to_send_clear   = clear_wr & pwdata[`SPIC_BIT_CTS];
   assign ring_indicator_clear  = clear_wr & pwdata[`SPIC_BIT_RI];

   // A zero bit leaves its strobe low, so that source keeps its state
   assign clr_d[`SPIC_BIT_OVERRUN]    = overrun_clear;
   assign clr_d[`SPIC_BIT_BREAK]      = break_clear;
   assign clr_d[`SPIC_BIT_PARITY]     = parity_error_clear;
   assign clr_d[`SPIC_BIT_FRAMING]    = framing_error_clear;
   assign clr_d[`SPIC_BIT_RX_TIMEOUT] = receive_timeout_clear;
   assign clr_d[`SPIC_BIT_TRANSMIT]   = transmit_irq_clear;
   assign clr_d[`SPIC_BIT_RECEIVE]    = receive_irq_clear;
   assign clr_d[`SPIC_BIT_DSR]        = data_set_ready_clear;
   assign clr_d[`SPIC_BIT_DCD]        = carrier_detect_clear;
   assign clr_d[`SPIC_BIT_CTS]        = clear_to_send_clear;
   assign clr_d[`SPIC_BIT_RI]         = ring_indicator_clear;

   // Combined interrupt sees only enabled sources
   assign mstat         = raw_q & mask_q;
   assign masked_status = mstat;
   assign clear_strobe  = clr_q;
   assign uart_irq      = |mstat;

   // Upper bits of every read word are zero
   assign rd_raw   = {`SPIC_PAD_ZERO, raw_q};
   assign rd_mask  = {`SPIC_PAD_ZERO, mask_q};
   assign rd_mstat = {`SPIC_PAD_ZERO, mstat};
   assign rd_clear = `SPIC_RST_DATA;

   // Sticky status per source; a new event beats a clear in the same cycle
   genvar i;
   generate
      for (i = 0; i < `SPIC_NSRC; i = i + 1) begin : g_src
         wire set_now;
         wire clr_now;

         // Priority made explicit so an event is never lost to a clear
         assign set_now = src_event[i];
         assign clr_now = clr_d[i] & ~set_now;

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               raw_q[i] <= 1'b0;
            end else if (set_now) begin
               raw_q[i] <= 1'b1;
            end else if (clr_now) begin
               raw_q[i] <= 1'b0;
            end
         end

         // One-cycle strobe towards the port's status logic
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               clr_q[i] <= 1'b0;
            end else begin
               clr_q[i] <= clr_d[i];
            end
         end
      end
   endgenerate

   // Mask: a one lets its source reach the combined interrupt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= `SPIC_RST_MASK;
      end else if (mask_wr) begin
         mask_q <= pwdata[`SPIC_NSRC-1:0];
      end
   end

   // Clear register has no readable state
   always @* begin
      rdata_d = `SPIC_RST_DATA;
      case (paddr)
         `SPIC_ADDR_RAW_STATUS: begin
            rdata_d = rd_raw;
         end
         `SPIC_ADDR_MASK: begin
            rdata_d = rd_mask;
         end
         `SPIC_ADDR_MASKED_STATUS: begin
            rdata_d = rd_mstat;
         end
         `SPIC_ADDR_INT_CLEAR: begin
            rdata_d = rd_clear;
         end
         default: begin
            rdata_d = `SPIC_RST_DATA;
         end
      endcase
   end

   // Read data captured in setup so it comes from a flop in access;
   // a write loads zero so a stale read word never lingers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= `SPIC_RST_DATA;
      end else if (setup) begin
         if (pwrite) begin
            rdata_q <= `SPIC_RST_DATA;
         end else begin
            rdata_q <= rdata_d;
         end
      end
   end

   // Unmapped addresses are answered with an error in the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_q <= 1'b0;
      end else if (setup) begin
         err_q <= ~hit;
      end
   end

endmodule // spic_top

// ### design/spic_consts.vh
// Constants for the serial port interrupt clear block
`ifndef SPIC_CONSTS_VH
`define SPIC_CONSTS_VH

// Register byte addresses
`define SPIC_ADDR_RAW_STATUS    12'h000
`define SPIC_ADDR_MASK          12'h004
`define SPIC_ADDR_MASKED_STATUS 12'h008
`define SPIC_ADDR_INT_CLEAR     12'h00C

// Widths
`define SPIC_NSRC               11
`define SPIC_AW                 12
`define SPIC_DW                 32
`define SPIC_PAD_W              21

// Source bit positions in every interrupt register
`define SPIC_BIT_OVERRUN        10
`define SPIC_BIT_BREAK          9
`define SPIC_BIT_PARITY         8
`define SPIC_BIT_FRAMING        7
`define SPIC_BIT_RX_TIMEOUT     6
`define SPIC_BIT_TRANSMIT       5
`define SPIC_BIT_RECEIVE        4
`define SPIC_BIT_DSR            3
`define SPIC_BIT_DCD            2
`define SPIC_BIT_CTS            1
`define SPIC_BIT_RI             0

// Reset values
`define SPIC_RST_STATUS         11'h000
`define SPIC_RST_MASK           11'h000
`define SPIC_RST_DATA           32'h0000_0000
`define SPIC_PAD_ZERO           21'h00_0000

`endif

// ### verif/spic_chk.sv
// Checker for the interrupt clear block
`timescale 1ns/100ps
module spic_chk (
   // Bus side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Port side
   input wire logic [10:0] src_event,
   input wire logic [10:0] clear_strobe,
   input wire logic [10:0] masked_status,
   input wire logic        uart_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire        wr    = psel && penable && pwrite && paddr == 12'h00C;
   wire        rd    = psel && penable && !pwrite && paddr == 12'h00C;
   wire [10:0] wbits = pwdata[10:0];
   AST_RD0: assert property (rd |-> prdata == 32'h0000_0000)
      else $error("clear reg read");
   AST_STB: assert property (wr |=> clear_strobe == $past(wbits))
      else $error("strobe");
   // Events set bits, so only quiet cycles pin the result
   AST_KEEP: assert property (wr && src_event == 11'h000 |=>
      masked_status == ($past(masked_status) & ~$past(wbits))) else $error("keep");
   AST_BRK: assert property (wr && pwdata[9] && !src_event[9] |=> !masked_status[9])
      else $error("break");
   AST_DCD: assert property (wr && pwdata[2] && !src_event[2] |=> !masked_status[2])
      else $error("dcd");
   AST_IRQ: assert property (uart_irq == |masked_status) else $error("irq");
   AST_RST: assert property ($rose(presetn) |-> masked_status == 11'h000) else $error("rst");
endmodule // spic_chk
bind spic_top spic_chk u_chk (
   .pclk          (pclk),
   .presetn       (presetn),
   .psel          (psel),
   .penable       (penable),
   .pwrite        (pwrite),
   .paddr         (paddr),
   .pwdata        (pwdata),
   .prdata        (prdata),
   .src_event     (src_event),
   .clear_strobe  (clear_strobe),
   .masked_status (masked_status),
   .uart_irq      (uart_irq)
);

// ### verif/spic_top_tb_top.sv
// Bench for the interrupt clear block
`timescale 1ns/100ps
module spic_top_tb_top;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        pready, pslverr, uart_irq, pe;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [10:0] src_event = 0, clear_strobe, masked_status, exp;
   int          err_total = 0, comparisons = 0;
   spic_top u_dut (
      .pclk          (pclk),
      .presetn       (presetn),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .paddr         (paddr),
      .pwdata        (pwdata),
      .pready        (pready),
      .pslverr       (pslverr),
      .prdata        (prdata),
      .src_event     (src_event),
      .clear_strobe  (clear_strobe),
      .masked_status (masked_status),
      .uart_irq      (uart_irq)
   );
   initial forever #12.5 pclk = ~pclk;
   task automatic chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      pe = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic pulse(input logic [10:0] s);
      @(posedge pclk) src_event <= s;
      @(posedge pclk) src_event <= 11'h000;
   endtask
   task t_clear;
      xfer(1'b1, 12'h004, 32'h0000_07FF);
      pulse(11'h7FF);
      exp = 11'h7FF;
      for (int i = 10; i >= 0; i--) begin
         xfer(1'b1, 12'h00C, 32'h0000_0001 << i);
         exp[i] = 1'b0;
         @(negedge pclk) chk(masked_status, exp);
         chk(clear_strobe, 32'h0000_0001 << i);
         chk(uart_irq, |exp);
      end
      $display("t_clear done");
   endtask
   task t_read;
      pulse(11'h7FF);
      xfer(1'b0, 12'h00C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(pe, 1'b0);
      xfer(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_07FF);
      xfer(1'b1, 12'h00C, 32'h0000_0000);
      @(negedge pclk) chk(masked_status, 11'h7FF);
      xfer(1'b1, 12'h00C, 32'h0000_07FF);
      @(negedge pclk) chk(masked_status, 11'h000);
      chk(clear_strobe, 32'h0000_07FF);
      xfer(1'b0, 12'h010, 32'h0000_0000);
      chk(pe, 1'b1);
      $display("t_read done");
   endtask
   task t_reset;
      pulse(11'h7FF);
      @(negedge pclk) chk(uart_irq, 1'b1);
      @(posedge pclk) presetn <= 1'b0;
      @(negedge pclk) chk(masked_status, 11'h000);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk) chk(uart_irq, 1'b0);
      pulse(11'h010);
      @(negedge pclk) chk(masked_status, 11'h000);
      chk(uart_irq, 1'b0);
      xfer(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0010);
      $display("t_reset done");
   endtask
   task end_of_test;
      $display("Compared %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk) chk(masked_status, 11'h000);
      t_clear;
      t_read;
      t_reset;
      end_of_test;
   end
   initial begin
      #20us;
      err_total++;
      end_of_test;
   end
endmodule // spic_top_tb_top
